//--- verilog/etos_pkg.sv
/*
 Constants and types of the E1 transmit overhead source selector.
 Assumes register indices are word indices: byte address is four times the index.
*/
package etos_pkg;
  localparam int         IDX_W = 10;
  localparam logic [9:0] SMC_IDX = 10'h109;
  localparam logic [9:0] TSL_IDX = 10'h10A;
  localparam logic [9:0] SPS_IDX = 10'h130;
  localparam logic [9:0] SPV_IDX = 10'h131;
  localparam logic [9:0] CTL_IDX = 10'h132;
  localparam logic [9:0] STA_IDX = 10'h133;
  localparam logic [9:0] BANK_LO = 10'h340;
  localparam logic [9:0] BANK_HI = 10'h35F;
  localparam int SMC_FAS_SRC   = 0;
  localparam int SMC_CRC_SRC   = 1;
  localparam int SMC_DL_LSB    = 2;
  localparam int SMC_E_LSB     = 6;
  localparam int CTL_CRC_EN    = 0;
  localparam int CTL_TS16_LSB  = 1;
  localparam int CTL_DE_EN     = 3;
  localparam int CTL_DE_ALT    = 4;
  localparam int CTL_DE_LSB    = 8;
  localparam int STA_OVF       = 0;
  localparam int STA_SLOT_LSB  = 8;
  localparam int STA_FRAME_LSB = 16;
  localparam logic [2:0]  SA_LO     = 3'h3;
  localparam logic [7:0]  SMC_RESET = 8'h00;
  localparam logic [7:0]  TSL_RESET = 8'h00;
  localparam logic [7:0]  SPS_RESET = 8'h00;
  localparam logic [7:0]  SPV_RESET = 8'hFF;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [2:0]  SIG_DL       = 3'h0;
  localparam logic [2:0]  SIG_CAS      = 3'h1;
  localparam logic [2:0]  SIG_ONES     = 3'h2;
  localparam logic [2:0]  SIG_ONES_CAS = 3'h3;
  localparam logic [2:0]  SIG_DE_SIG   = 3'h4;
  localparam logic [1:0]  DL_HDLC   = 2'h1;
  localparam logic [1:0]  DL_OVH    = 2'h2;
  localparam logic [1:0]  E_ZERO    = 2'h1;
  localparam logic [1:0]  E_ONE     = 2'h2;
  localparam logic [1:0]  E_LINK    = 2'h3;
  localparam logic [7:0]  FAS_PATTERN = 8'hD8;
  localparam logic [5:0]  MF_PATTERN  = 6'h34;
  localparam logic        A_IDLE      = 1'b0;
  localparam logic [4:0]  TS16        = 5'h10;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_ERR    = 2'h2;
  typedef enum logic [1:0] {TS16_SER, TS16_BANK, TS16_OVH, TS16_SIG} etos_ts16_type;
  typedef enum logic [2:0] {R_SMC, R_TSL, R_SPS, R_SPV, R_CTL, R_STA, R_BANK, R_NONE}
    etos_reg_type;
endpackage

//--- verilog/etos_sync.sv
/*
 Three-stage synchroniser; a level is taken once stages two and three agree.
 Assumes inputs change far slower than clk_i.
*/
`timescale 1ns/100ps
module etos_sync
  import etos_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] lvl_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } etos_sync_state_type;

  etos_sync_state_type s_q;
  etos_sync_state_type s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign lvl_o = s_q.lvl;
endmodule

//--- verilog/etos_buf.sv
/*
 Two-entry buffer with registered outputs and valid/ready on both sides.
 Assumes the drain side may hold ready low for any time.
*/
`timescale 1ns/100ps
module etos_buf
  import etos_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  typedef struct packed {
    logic         ov;
    logic [W-1:0] od;
    logic         sv;
    logic [W-1:0] sd;
  } etos_buf_state_type;

  etos_buf_state_type s_q;
  etos_buf_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (out_ready_i || !s_q.ov) begin
      if (s_q.sv) begin
        s_d.ov = 1'b1;
        s_d.od = s_q.sd;
        s_d.sv = 1'b0;
      end else begin
        s_d.ov = in_valid_i;
        s_d.od = in_data_i;
      end
    end else if (in_valid_i && !s_q.sv) begin
      s_d.sv = 1'b1;
      s_d.sd = in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign in_ready_o  = ~s_q.sv;
  assign out_valid_o = s_q.ov;
  assign out_data_o  = s_q.od;
endmodule

//--- verilog/etos_top.sv
/*
 E1 transmit overhead source selector: builds the outbound bit stream.
 Assumes tx_clk_i is a slow link clock sampled by clk_i; HDLC bit and
 receive CRC error inputs are on clk_i.
*/
`timescale 1ns/100ps
module etos_top
  import etos_pkg::*;
#(
  parameter int AW    = 12,
  parameter int DEPTH = 32
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          tx_clk_i,
  input  wire logic          tx_serial_in_i,
  input  wire logic          tx_fractional_data_in_i,
  input  wire logic          tx_signaling_in_i,
  input  wire logic          tx_overhead_in_i,
  input  wire logic          link_bit_in_i,
  input  wire logic          rx_crc_error_i,
  output logic               out_valid_o,
  output logic [1:0]         out_data_o,
  input  wire logic          out_ready_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  input  wire logic [AW-1:0] s_axi_awaddr_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  output logic [1:0]         s_axi_bresp_o,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  input  wire logic [AW-1:0] s_axi_araddr_i,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o
);
  typedef struct packed {
    logic [7:0]            smc;
    logic [7:0]            tsl;
    logic [7:0]            sps;
    logic [7:0]            spv;
    logic [15:0]           ctl;
    logic                  ovf;
    logic [DEPTH-1:0][7:0] bank;
    logic                  clk_lvl;
    logic [2:0]            bitn;
    logic [4:0]            slot;
    logic [3:0]            frame;
    logic [3:0]            crc;
    logic [3:0]            crch;
    logic                  aw_have;
    logic                  awready;
    logic                  w_have;
    logic                  wready;
    logic [IDX_W-1:0]      widx;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } etos_top_state_type;

  etos_top_state_type s_q;
  etos_top_state_type s_d;
  logic [4:0]         pin_lvl;
  logic               buf_ready;
  logic               tick;
  logic               ser;
  logic               val;
  logic               cbit;
  logic               smf;
  logic               crc_en;
  logic               fas_fr;
  logic               ebit;
  logic               fb;
  logic [2:0]         code;
  logic [2:0]         k;
  logic [1:0]         dl;
  logic [3:0]         crc_base;
  logic [3:0]         crc_hold;
  logic [IDX_W-1:0]   ridx;
  etos_ts16_type      ts16;

  function automatic etos_reg_type reg_of(input logic [IDX_W-1:0] idx);
    reg_of = R_NONE;
    case (idx)
      SMC_IDX: reg_of = R_SMC;
      TSL_IDX: reg_of = R_TSL;
      SPS_IDX: reg_of = R_SPS;
      SPV_IDX: reg_of = R_SPV;
      CTL_IDX: reg_of = R_CTL;
      STA_IDX: reg_of = R_STA;
      default: begin
        if (idx >= BANK_LO && idx <= BANK_HI) begin
          reg_of = R_BANK;
        end
      end
    endcase
  endfunction

  etos_sync #(
    .W (5)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({tx_clk_i, tx_overhead_in_i, tx_signaling_in_i,
             tx_fractional_data_in_i, tx_serial_in_i}),
    .lvl_o (pin_lvl)
  );

  etos_buf #(
    .W (2)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (tick),
    .in_data_i   ({smf && s_q.frame[3] == 1'b0, val}),
    .in_ready_o  (buf_ready),
    .out_valid_o (out_valid_o),
    .out_data_o  (out_data_o),
    .out_ready_i (out_ready_i)
  );

  always_comb begin
    s_d      = s_q;
    code     = (s_q.tsl[2:0] > SIG_DE_SIG) ? SIG_DL : s_q.tsl[2:0];
    dl       = s_q.smc[SMC_DL_LSB+:2];
    ts16     = etos_ts16_type'(s_q.ctl[CTL_TS16_LSB+:2]);
    tick     = pin_lvl[4] & ~s_q.clk_lvl;
    ser      = pin_lvl[0];
    k        = s_q.bitn;
    crc_en   = s_q.ctl[CTL_CRC_EN];
    fas_fr   = ~s_q.frame[0];
    smf      = (k == 3'h0) && (s_q.slot == 5'h00) && (s_q.frame[2:0] == 3'h0);
    crc_base = smf ? 4'h0 : s_q.crc;
    crc_hold = smf ? s_q.crc : s_q.crch;
    cbit     = 1'b0;
    ridx     = s_axi_araddr_i[IDX_W+1:2];
    val      = ser;
    case (s_q.smc[SMC_E_LSB+:2])
      E_ZERO:  ebit = 1'b0;
      E_ONE:   ebit = 1'b1;
      E_LINK:  ebit = link_bit_in_i;
      default: ebit = ~rx_crc_error_i;
    endcase

    // Outbound bit selection
    if (s_q.slot == 5'h00) begin
      if (fas_fr) begin
        if (k == 3'h0) begin
          if (crc_en) begin
            cbit = 1'b1;
            val  = s_q.smc[SMC_CRC_SRC] ? ser : crc_hold[2'h3 - s_q.frame[2:1]];
          end else begin
            val  = s_q.smc[SMC_FAS_SRC] ? ser : 1'b1;
          end
        end else if (!s_q.smc[SMC_FAS_SRC]) begin
          val = FAS_PATTERN[k];
        end
      end else if (k < SA_LO) begin
        if (!s_q.smc[SMC_FAS_SRC]) begin
          if (k == 3'h2) begin
            val = A_IDLE;
          end else if (k == 3'h1 || !crc_en) begin
            val = 1'b1;
          end else if (s_q.frame < 4'hC) begin
            val = MF_PATTERN[s_q.frame[3:1]];
          end else begin
            val = ebit;
          end
        end
      end else if (s_q.sps[k]) begin
        val = s_q.spv[k];
      end else if (code == SIG_ONES || code == SIG_ONES_CAS) begin
        val = 1'b1;
      end else if (!s_q.tsl[k]) begin
        val = 1'b1;
      end else begin
        case (dl)
          DL_HDLC: val = link_bit_in_i;
          DL_OVH:  val = pin_lvl[3];
          default: val = ser;
        endcase
      end
    end else if (s_q.ctl[CTL_DE_EN] && s_q.slot == s_q.ctl[CTL_DE_LSB+:5]) begin
      if (s_q.ctl[CTL_DE_ALT]) begin
        val = (code == SIG_DE_SIG) ? pin_lvl[2] : pin_lvl[1];
      end
    end else if (s_q.slot == TS16) begin
      case (code)
        SIG_CAS, SIG_ONES_CAS: begin
          case (ts16)
            TS16_BANK: val = s_q.bank[{1'b0, s_q.frame}][k];
            TS16_OVH:  val = pin_lvl[3];
            TS16_SIG:  val = pin_lvl[2];
            default:   val = ser;
          endcase
        end
        SIG_ONES: begin
          if (ts16 != TS16_SER) begin
            val = pin_lvl[2];
          end
        end
        default: val = ser;
      endcase
    end

    // Register writes
    if (s_axi_awvalid_i && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.widx    = s_axi_awaddr_i[IDX_W+1:2];
    end
    if (s_axi_wvalid_i && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata_i;
      s_d.wstrb  = s_axi_wstrb_i;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OK;
      case (reg_of(s_q.widx))
        R_SMC: if (s_q.wstrb[0]) s_d.smc = s_q.wdata[7:0];
        R_TSL: if (s_q.wstrb[0]) s_d.tsl = s_q.wdata[7:0];
        R_SPS: if (s_q.wstrb[0]) s_d.sps = s_q.wdata[7:0];
        R_SPV: if (s_q.wstrb[0]) s_d.spv = s_q.wdata[7:0];
        R_CTL: begin
          if (s_q.wstrb[0]) s_d.ctl[7:0] = s_q.wdata[7:0];
          if (s_q.wstrb[1]) s_d.ctl[15:8] = s_q.wdata[15:8];
        end
        R_STA: if (s_q.wstrb[0] && s_q.wdata[STA_OVF]) s_d.ovf = 1'b0;
        R_BANK: if (s_q.wstrb[0]) s_d.bank[s_q.widx[4:0]] = s_q.wdata[7:0];
        default: s_d.bresp = RESP_ERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid  = 1'b0;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
    end
    s_d.awready = ~s_d.aw_have;
    s_d.wready  = ~s_d.w_have;

    // Register reads
    if (s_axi_arvalid_i && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OK;
      s_d.rdata  = 32'h0000_0000;
      case (reg_of(ridx))
        R_SMC:  s_d.rdata[7:0] = s_q.smc;
        R_TSL:  s_d.rdata[7:0] = s_q.tsl;
        R_SPS:  s_d.rdata[7:0] = s_q.sps;
        R_SPV:  s_d.rdata[7:0] = s_q.spv;
        R_CTL:  s_d.rdata[15:0] = s_q.ctl;
        R_STA: begin
          s_d.rdata[STA_OVF]            = s_q.ovf;
          s_d.rdata[STA_SLOT_LSB+:5]    = s_q.slot;
          s_d.rdata[STA_FRAME_LSB+:4]   = s_q.frame;
        end
        R_BANK: s_d.rdata[7:0] = s_q.bank[ridx[4:0]];
        default: s_d.rresp = RESP_ERR;
      endcase
    end else if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = ~s_d.rvalid;

    // Position, CRC and overflow; overflow set wins over a clear
    fb = (cbit ? 1'b0 : val) ^ crc_base[3];
    if (tick) begin
      s_d.crc  = {crc_base[2:0], 1'b0} ^ {2'b00, fb, fb};
      s_d.crch = crc_hold;
      s_d.bitn = s_q.bitn + 3'h1;
      if (s_q.bitn == 3'h7) begin
        s_d.slot = s_q.slot + 5'h01;
        if (s_q.slot == 5'h1F) begin
          s_d.frame = s_q.frame + 4'h1;
        end
      end
      if (!buf_ready) begin
        s_d.ovf = 1'b1;
      end
    end
    s_d.clk_lvl = pin_lvl[4];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q     <= '0;
      s_q.smc <= SMC_RESET;
      s_q.tsl <= TSL_RESET;
      s_q.sps <= SPS_RESET;
      s_q.spv <= SPV_RESET;
      s_q.ctl <= CTL_RESET;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o  = s_q.wready;
  assign s_axi_bvalid_o  = s_q.bvalid;
  assign s_axi_bresp_o   = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o  = s_q.rvalid;
  assign s_axi_rdata_o   = s_q.rdata;
  assign s_axi_rresp_o   = s_q.rresp;

  // Checks on the selected bit and register behaviour
  logic push;
  logic ts0_sa;
  assign push   = tick & ce_i;
  assign ts0_sa = push && s_q.slot == 5'h00 && !fas_fr && k >= SA_LO;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  crc_ignored_a: assert property (
    push && s_q.slot == 5'h00 && fas_fr && k == 3'h0 && !crc_en
    |-> val == (s_q.smc[SMC_FAS_SRC] ? ser : 1'b1))
    else $error("CRC source not ignored");
  crc_serial_a: assert property (
    push && s_q.slot == 5'h00 && fas_fr && k == 3'h0 && crc_en && s_q.smc[SMC_CRC_SRC]
    |-> val == ser)
    else $error("CRC bit not from serial input");
  fas_internal_a: assert property (
    push && s_q.slot == 5'h00 && fas_fr && k != 3'h0 && !s_q.smc[SMC_FAS_SRC]
    |-> val == FAS_PATTERN[k])
    else $error("FAS pattern bit wrong");
  ebit_force_a: assert property (
    push && s_q.slot == 5'h00 && !fas_fr && k == 3'h0 && crc_en && s_q.frame >= 4'hC
    && !s_q.smc[SMC_FAS_SRC] && s_q.smc[SMC_E_LSB+:2] == E_ZERO |-> !val)
    else $error("E bit not forced to zero");
  sa_idle_one_a: assert property (
    ts0_sa && !s_q.sps[k] && !s_q.tsl[k] |-> val)
    else $error("Disabled spare bit not one");
  sa_register_a: assert property (
    ts0_sa && s_q.sps[k] |-> val == s_q.spv[k])
    else $error("Spare bit not from register");
  sa_hdlc_a: assert property (
    ts0_sa && !s_q.sps[k] && s_q.tsl[k] && code != SIG_ONES && code != SIG_ONES_CAS
    && dl == DL_HDLC |-> val == link_bit_in_i)
    else $error("Spare bit not carrying link bit");
  nat_ones_a: assert property (
    ts0_sa && !s_q.sps[k] && s_q.tsl[1] && !s_q.tsl[2] |-> val)
    else $error("National bits not forced to one");
  unused_code_a: assert property (
    push && s_q.slot == TS16 && s_q.tsl[2:0] > SIG_DE_SIG && !s_q.ctl[CTL_DE_EN]
    |-> val == ser)
    else $error("Unused code not acting as default");
  bit_step_a: assert property (
    push |=> s_q.bitn == $past(s_q.bitn) + 3'h1)
    else $error("Bit position did not advance");
  write_resp_a: assert property (
    ce_i && s_q.aw_have && s_q.w_have && !s_q.bvalid |=> s_q.bvalid)
    else $error("Write response missing");
endmodule

//--- testbench/etos_term_model.sv
/*
 Terminal equipment model: free-running link clock and the four serial lines.
 Assumes the bench sets the wanted line levels through lvl_i.
*/
`timescale 1ns/100ps
module etos_term_model (
  input  wire logic [3:0] lvl_i,
  output logic            tx_clk_o,
  output logic [3:0]      line_o
);
  // E1 line clock runs free, every edge falling 2 ns before a system clock rise
  initial begin
    tx_clk_o = 1'h0;
    line_o   = 4'h0;
    #33;
    forever #80 tx_clk_o = ~tx_clk_o;
  end
  // Lines change on the falling edge, stable at the sampling rise
  always @(negedge tx_clk_o) begin
    line_o <= lvl_i;
  end
endmodule

//--- testbench/tb.sv
/*
 Self-checking bench of the E1 transmit overhead source selector.
 Assumes the terminal model etos_term_model and default design parameters.
*/
`timescale 1ns/100ps
module tb
  import etos_pkg::*;
;
  typedef struct packed {
    logic [7:0]  tsl;
    logic [7:0]  smc;
    logic [7:0]  sps;
    logic [7:0]  spv;
    logic [15:0] ctl;
    logic [3:0]  lvl;
    logic        link;
    logic [4:0]  fsel;
    logic [4:0]  slot;
    logic [2:0]  bitn;
    logic        exp;
  } etos_row_type;
  // Line levels are {overhead, signaling, fractional, serial}
  localparam etos_row_type ROWS [17] = '{
    '{8'h00, 8'h00, 8'h00, 8'hFF, 16'h0000, 4'h0, 1'h0, 5'h11, 5'h00, 3'h7, 1'h1},
    '{8'h00, 8'h00, 8'h00, 8'hFF, 16'h0002, 4'h0, 1'h0, 5'h12, 5'h10, 3'h0, 1'h0},
    '{8'h00, 8'h02, 8'h00, 8'hFF, 16'h0000, 4'h0, 1'h0, 5'h10, 5'h00, 3'h0, 1'h1},
    '{8'h01, 8'h00, 8'h00, 8'hFF, 16'h0002, 4'h0, 1'h0, 5'h12, 5'h10, 3'h5, 1'h1},
    '{8'h00, 8'h00, 8'hF8, 8'h80, 16'h0000, 4'h1, 1'h0, 5'h11, 5'h00, 3'h3, 1'h0},
    '{8'h01, 8'h00, 8'h00, 8'hFF, 16'h0004, 4'h1, 1'h0, 5'h12, 5'h10, 3'h2, 1'h0},
    '{8'h00, 8'h02, 8'h00, 8'hFF, 16'h0001, 4'h0, 1'h0, 5'h10, 5'h00, 3'h0, 1'h0},
    '{8'h03, 8'h00, 8'h00, 8'hFF, 16'h0006, 4'h9, 1'h0, 5'h12, 5'h10, 3'h1, 1'h0},
    '{8'hFA, 8'h00, 8'h00, 8'hFF, 16'h0000, 4'h0, 1'h0, 5'h11, 5'h00, 3'h4, 1'h1},
    '{8'h02, 8'h00, 8'h00, 8'hFF, 16'h0002, 4'h4, 1'h0, 5'h12, 5'h10, 3'h6, 1'h1},
    '{8'h04, 8'h00, 8'h00, 8'hFF, 16'h0518, 4'h4, 1'h0, 5'h12, 5'h05, 3'h3, 1'h1},
    '{8'h05, 8'h00, 8'h00, 8'hFF, 16'h0002, 4'h0, 1'h0, 5'h12, 5'h10, 3'h4, 1'h0},
    '{8'h00, 8'h00, 8'h00, 8'hFF, 16'h0518, 4'h2, 1'h0, 5'h12, 5'h05, 3'h3, 1'h1},
    '{8'h80, 8'h04, 8'h00, 8'hFF, 16'h0000, 4'h1, 1'h0, 5'h11, 5'h00, 3'h7, 1'h0},
    '{8'h00, 8'h01, 8'h00, 8'hFF, 16'h0000, 4'h1, 1'h0, 5'h11, 5'h00, 3'h2, 1'h1},
    '{8'h00, 8'h41, 8'h00, 8'hFF, 16'h0001, 4'h1, 1'h0, 5'h0D, 5'h00, 3'h0, 1'h1},
    '{8'h00, 8'h40, 8'h00, 8'hFF, 16'h0001, 4'h1, 1'h0, 5'h0F, 5'h00, 3'h0, 1'h0}
  };
  localparam logic [9:0]  RIDX [5] = '{SMC_IDX, TSL_IDX, SPS_IDX, SPV_IDX, CTL_IDX};
  localparam logic [15:0] REXP [5] = '{16'(SMC_RESET), 16'(TSL_RESET), 16'(SPS_RESET),
                                       16'(SPV_RESET), CTL_RESET};
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        ready = 1'h1;
  logic        link_bit = 1'h0;
  logic [3:0]  lvl = 4'h0;
  logic        tx_clk;
  logic [3:0]  line;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, out_valid;
  logic [1:0]  bresp, rresp, out_data;
  logic [31:0] rdata;
  logic [1:0]  strm [0:8191];
  int          bit_cnt = 0;
  int          miscompares = 0;
  int          check_count = 0;

  always #5 clk = ~clk;

  etos_term_model i_etos_term_model (.lvl_i(lvl), .tx_clk_o(tx_clk), .line_o(line));

  etos_top i_etos_top (
    .clk_i(clk), .rst_i(rst), .ce_i(1'h1), .tx_clk_i(tx_clk),
    .tx_serial_in_i(line[0]), .tx_fractional_data_in_i(line[1]),
    .tx_signaling_in_i(line[2]), .tx_overhead_in_i(line[3]),
    .link_bit_in_i(link_bit), .rx_crc_error_i(1'h0),
    .out_valid_o(out_valid), .out_data_o(out_data), .out_ready_i(ready),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp));

  // Outbound bit log, indexed by position since reset
  always @(posedge clk) begin
    if (rst) begin
      bit_cnt <= 0;
    end else if (out_valid && ready) begin
      strm[bit_cnt[12:0]] <= out_data;
      bit_cnt <= bit_cnt + 1;
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    wstrb <= s;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'h0;
    check("write answered", 32'h1, 32'(bvalid));
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'h1;
    rready <= 1'h1;
    araddr <= {idx, 2'h0};
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    check("read answered", 32'h1, 32'(rvalid));
    rready <= 1'h0;
  endtask

  task automatic cfg(input etos_row_type w);
    logic [1:0] r;
    wr(TSL_IDX, 32'(w.tsl), 4'hF, r);
    wr(SMC_IDX, 32'(w.smc), 4'hF, r);
    wr(SPS_IDX, 32'(w.sps), 4'hF, r);
    wr(SPV_IDX, 32'(w.spv), 4'hF, r);
    wr(CTL_IDX, 32'(w.ctl), 4'hF, r);
    lvl <= w.lvl;
    link_bit <= w.link;
  endtask

  function automatic logic hit(input int i, input etos_row_type w);
    int f;
    f = (i >> 8) % 16;
    if ((i >> 3) % 32 != int'(w.slot) || i % 8 != int'(w.bitn)) return 1'h0;
    return w.fsel == 5'h12 || (w.fsel == 5'h10 && f % 2 == 0) ||
           (w.fsel == 5'h11 && f % 2 == 1) || int'(w.fsel) == f;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    int          i;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 16; k++) wr(BANK_LO + 10'(k), 32'h0000_00FF, 4'hF, r);
    foreach (ROWS[k]) begin
      cfg(ROWS[k]);
      i = bit_cnt + 24;
      while (!hit(i, ROWS[k])) i++;
      n = 0;
      while (bit_cnt <= i && n < 20000) begin
        @(posedge clk);
        n++;
      end
      check("row bit reached", 32'h1, 32'(bit_cnt > i));
      check($sformatf("row %0d bit", k), 32'(ROWS[k].exp), 32'(strm[i[12:0]][0]));
      $display("test row %0d done", k);
    end
    // Unmapped place and byte-lane gating
    rd(10'h000, d, r);
    check("unmapped read resp", 32'(RESP_ERR), 32'(r));
    check("unmapped read data", 32'h0000_0000, d);
    wr(10'h000, 32'h0000_00FF, 4'hF, r);
    check("unmapped write resp", 32'(RESP_ERR), 32'(r));
    wr(SMC_IDX, 32'h0000_00C3, 4'h0, r);
    rd(SMC_IDX, d, r);
    check("masked write", 32'(ROWS[16].smc), d);
    $display("test register bus done");
    // Short stall loses nothing, long stall overflows
    ready <= 1'h0;
    repeat (20) @(posedge clk);
    check("held valid", 32'h1, 32'(out_valid));
    rd(STA_IDX, d, r);
    check("no overflow", 32'h0, 32'(d[STA_OVF]));
    repeat (80) @(posedge clk);
    rd(STA_IDX, d, r);
    check("overflow", 32'h1, 32'(d[STA_OVF]));
    ready <= 1'h1;
    wr(STA_IDX, 32'h0000_0001, 4'hF, r);
    rd(STA_IDX, d, r);
    check("overflow cleared", 32'h0, 32'(d[STA_OVF]));
    $display("test buffer done");
    // Reset in mid-run restores registers and stream position
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    foreach (RIDX[k]) begin
      rd(RIDX[k], d, r);
      check($sformatf("reset value %0d", k), 32'(REXP[k]), d);
    end
    n = 0;
    while (bit_cnt < 2 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("bits after reset", 32'h1, 32'(bit_cnt >= 2));
    check("multiframe start mark", 32'h1, 32'(strm[0][1]));
    check("second bit mark", 32'h0, 32'(strm[1][1]));
    $display("test reset done");
    give_verdict();
  end

  initial begin
    #900_000;
    miscompares++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
